// ===== rtl/prp_params.svh
/*
  constants of the rmii pin block: timing counts, management frame
  layout, management register offsets, field positions and reset values.
  assumes the includer runs on clk_sys at 20 MHz.
*/
`ifndef PRP_PARAMS_SVH
`define PRP_PARAMS_SVH
// system clock period
`define PRP_CLK_NS 50
// least low time of the hard reset pin
`define PRP_RST_HOLD_NS 1000
// reset process length, rounded up
`define PRP_RST_CYC ((`PRP_RST_HOLD_NS + `PRP_CLK_NS - 1) / `PRP_CLK_NS)
// indicator blink half period
`define PRP_BLINK_NS 50000000
`define PRP_BLINK_CYC (`PRP_BLINK_NS / `PRP_CLK_NS)
// management frame layout
`define PRP_MD_PRE_LEN 6'h20
`define PRP_MD_HDR_LAST 6'h0D
`define PRP_MD_DATA_LAST 6'h0F
`define PRP_MD_ST 2'h1
`define PRP_MD_OP_RD 2'h2
`define PRP_MD_OP_WR 2'h1
`define PRP_PHY_ADDR 5'h01
// management register offsets
`define PRP_REG_CFG 5'h10
`define PRP_REG_STAT 5'h11
// config field positions and reset value
`define PRP_CFG_LED_GPIO 0
`define PRP_CFG_LED_DIR 1
`define PRP_CFG_LED_VAL 2
`define PRP_CFG_INTR 3
`define PRP_CFG_RST 16'h0000
`endif

// ===== rtl/prp_pkg.sv
/*
  types of the rmii pin block: management engine states and indicator modes.
  assumes nothing of its surroundings.
*/
package prp_pkg;
  // management frame engine states
  typedef enum logic [3:0] {
    PRP_MD_PRE  = 4'h1,
    PRP_MD_HDR  = 4'h2,
    PRP_MD_TA   = 4'h4,
    PRP_MD_DATA = 4'h8
  } prp_md_state_t;
  // indicator pin modes
  typedef enum logic [3:0] {
    PRP_LED_OFF   = 4'h1,
    PRP_LED_ON    = 4'h2,
    PRP_LED_BLINK = 4'h4,
    PRP_LED_GPIO  = 4'h8
  } prp_led_mode_t;
endpackage

// ===== rtl/prp_mgmt_if.sv
/*
  carrier between the pin core and the management engine.
  assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface prp_mgmt_if;
  logic        mdc_lvl;   // filtered management clock level
  logic        mdio_lvl;  // filtered management data level
  logic [15:0] stat;      // status word read by the station
  logic [15:0] cfg;       // config word written by the station
  logic        mdio_o;    // data driven onto the pin
  logic        mdio_oe;   // high while the engine drives the pin
  modport engine (input mdc_lvl, mdio_lvl, stat, output cfg, mdio_o, mdio_oe);
  modport core (output mdc_lvl, mdio_lvl, stat, input cfg, mdio_o, mdio_oe);
endinterface

// ===== rtl/prp_sync.sv
/*
  three-stage pin synchroniser with agreement filter.
  assumes asynchronous pin inputs and one system clock.
*/
`timescale 1ns/1ps
module prp_sync #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;  // first stage, read only by s2_r
  logic [W-1:0] s2_r;  // second stage
  logic [W-1:0] s3_r;  // third stage
  logic [W-1:0] q_r;   // accepted level

  // shift chain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
    end else if (clk_en) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= RST;
    end else if (clk_en) begin
      q_r <= (s2_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
    end
  end

  assign q = q_r;

  a_sync_agree: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_r != $past(q_r)) |-> ($past(s2_r ^ s3_r) & (q_r ^ $past(q_r))) == '0)
    else $error("filtered level changed before stages agreed");
endmodule

// ===== rtl/prp_mdio.sv
/*
  management frame engine: preamble, header, turnaround and data,
  with a config word and a status word.
  assumes management clock and data already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`include "prp_params.svh"
module prp_mdio #(
  parameter logic [4:0] PHY_ADDR = `PRP_PHY_ADDR
) (
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  prp_mgmt_if.engine mif
);
  prp_pkg::prp_md_state_t st_r;  // frame state
  logic        mdc_q_r;          // previous clock level
  logic        rise;             // management clock rising edge
  logic [5:0]  cnt_r;            // bit counter
  logic [15:0] sh_r;             // received bits
  logic [15:0] tx_sh_r;          // read data still to send
  logic        rd_r;             // frame is a read
  logic [4:0]  reg_r;            // addressed register
  logic [15:0] cfg_r;            // config word
  logic        o_r;              // pin data
  logic        oe_r;             // pin enable
  logic [13:0] hdr;              // complete header on its last bit
  logic [15:0] rd_val;           // word answered on a read

  assign rise = mif.mdc_lvl & ~mdc_q_r;
  assign hdr = {sh_r[12:0], mif.mdio_lvl};

  // read mux, unmapped offsets answer zero
  always_comb begin
    case (reg_r)
      `PRP_REG_CFG:  rd_val = cfg_r;
      `PRP_REG_STAT: rd_val = mif.stat;
      default:       rd_val = 16'h0000;
    endcase
  end

  // clock edge detect
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdc_q_r <= 1'b0;
    end else if (clk_en) begin
      mdc_q_r <= mif.mdc_lvl;
    end
  end

  // frame engine; the device drives only in its own phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= prp_pkg::PRP_MD_PRE;
      cnt_r <= 6'h00;
      sh_r <= 16'h0000;
      tx_sh_r <= 16'h0000;
      rd_r <= 1'b0;
      reg_r <= 5'h00;
      o_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (clk_en && rise) begin
      sh_r <= {sh_r[14:0], mif.mdio_lvl};
      case (st_r)
        prp_pkg::PRP_MD_PRE: begin
          if (mif.mdio_lvl) begin
            cnt_r <= (cnt_r == `PRP_MD_PRE_LEN) ? cnt_r : cnt_r + 6'h01;
          end else if (cnt_r == `PRP_MD_PRE_LEN) begin
            st_r <= prp_pkg::PRP_MD_HDR;
            cnt_r <= 6'h01;
          end else begin
            cnt_r <= 6'h00;
          end
        end
        prp_pkg::PRP_MD_HDR: begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == `PRP_MD_HDR_LAST) begin
            cnt_r <= 6'h00;
            rd_r <= hdr[11:10] == `PRP_MD_OP_RD;
            reg_r <= hdr[4:0];
            // foreign address or bad opcode: back to preamble hunt
            if (hdr[13:12] == `PRP_MD_ST && hdr[9:5] == PHY_ADDR &&
                (hdr[11:10] == `PRP_MD_OP_RD || hdr[11:10] == `PRP_MD_OP_WR)) begin
              st_r <= prp_pkg::PRP_MD_TA;
            end else begin
              st_r <= prp_pkg::PRP_MD_PRE;
            end
          end
        end
        prp_pkg::PRP_MD_TA: begin
          cnt_r <= cnt_r + 6'h01;
          // second turnaround bit is driven low on a read
          if (cnt_r == 6'h00) begin
            oe_r <= rd_r;
            o_r <= 1'b0;
          end else begin
            st_r <= prp_pkg::PRP_MD_DATA;
            cnt_r <= 6'h00;
            o_r <= rd_val[15];
            tx_sh_r <= {rd_val[14:0], 1'b0};
          end
        end
        prp_pkg::PRP_MD_DATA: begin
          cnt_r <= cnt_r + 6'h01;
          o_r <= tx_sh_r[15];
          tx_sh_r <= {tx_sh_r[14:0], 1'b0};
          if (cnt_r == `PRP_MD_DATA_LAST) begin
            st_r <= prp_pkg::PRP_MD_PRE;
            cnt_r <= 6'h00;
            oe_r <= 1'b0;
          end
        end
        default: begin
          st_r <= prp_pkg::PRP_MD_PRE;
          cnt_r <= 6'h00;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  // config word, back to default on each reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `PRP_CFG_RST;
    end else if (clk_en && rise && st_r == prp_pkg::PRP_MD_DATA && !rd_r &&
                 cnt_r == `PRP_MD_DATA_LAST && reg_r == `PRP_REG_CFG) begin
      cfg_r <= {sh_r[14:0], mif.mdio_lvl};
    end
  end

  assign mif.cfg = cfg_r;
  assign mif.mdio_o = o_r;
  assign mif.mdio_oe = oe_r;

  a_mdio_own_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    oe_r |-> rd_r && (st_r == prp_pkg::PRP_MD_TA || st_r == prp_pkg::PRP_MD_DATA))
    else $error("data pin driven outside a read phase");
  c_mdio_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(oe_r));
endmodule

// ===== rtl/prp_top.sv
/*
  mac-facing pin logic of a 10/100 ethernet transceiver: rmii receive and
  transmit pins, management pins, hard reset, straps, the indicator pin
  and the shared interrupt / power-down pin.
  assumes clk_sys is the rmii reference clock domain, that the mac and the
  internal pcs run on it, and that mdc, mdio, and the two shared pins come
  from outside and are asynchronous.
*/
`timescale 1ns/1ps
`include "prp_params.svh"
module prp_top #(
  parameter int unsigned BLINK_CYC = `PRP_BLINK_CYC,
  parameter int unsigned BLINK_W   = 20,
  parameter logic [4:0]  PHY_ADDR  = `PRP_PHY_ADDR
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [3:0] strap_i,
  input  wire logic       link_up,
  input  wire logic       irq_event,
  input  wire logic       tx_en,
  input  wire logic [1:0] tx_d,
  output logic            line_tx_en,
  output logic      [1:0] line_tx_d,
  input  wire logic       line_rx_dv,
  input  wire logic       line_crs,
  input  wire logic [1:0] line_rx_d,
  input  wire logic       line_rx_sym_err,
  output logic      [1:0] rx_d,
  output logic            crs_dv,
  output logic            rx_er,
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  input  wire logic       activity_link_indicator_i,
  output logic            activity_link_indicator_o,
  output logic            activity_link_indicator_oe,
  input  wire logic       interrupt_powerdown_pin_i,
  output logic            interrupt_powerdown_pin_o,
  output logic            interrupt_powerdown_pin_oe,
  output logic            powerdown,
  output logic            ready
);
  // reset process length in cycles
  localparam logic [4:0] RST_CYC = 5'(`PRP_RST_CYC);
  // idle pin levels: mdc low, pulled-up data and power-down, indicator low
  localparam logic [3:0] PIN_RST = 4'h6;

  prp_mgmt_if mif ();

  logic [3:0] pin_lvl;        // filtered pin levels
  logic       pd_lvl;         // power-down pin level
  logic       led_lvl;        // indicator pin level
  logic [3:0] strap_r;        // straps caught after reset
  logic       strap_done_r;   // straps taken
  logic [4:0] init_cnt_r;     // reset process counter
  logic       ready_r;        // reset process done
  logic       powerdown_r;    // power-down state
  logic       intr_o_r;       // open-drain level, always low
  logic       intr_oe_r;      // pulls the shared pin low
  logic       active;         // pins may carry frames
  logic       intr_mode;      // shared pin is an interrupt
  logic       gpio_mode;      // indicator pin is gpio
  logic       line_tx_en_r;   // frame data to the line
  logic [1:0] line_tx_d_r;    // dibit to the line
  logic [1:0] rx_d_r;         // dibit to the mac
  logic       crs_dv_r;       // merged carrier and valid
  logic       rx_er_r;        // receive error flag
  logic       led_o_r;        // indicator drive level
  logic       led_oe_r;       // indicator drive enable
  logic       act_now;        // activity in this cycle
  logic [BLINK_W-1:0] act_cnt_r;    // activity hold window
  logic [BLINK_W-1:0] blink_cnt_r;  // blink half-period timer
  logic       blink_ph_r;     // blink phase
  prp_pkg::prp_led_mode_t led_mode;  // indicator mode now

  // the management pins and the two shared pins pass the three-stage filter
  prp_sync #(
    .W   (4),
    .RST (PIN_RST)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .d       ({activity_link_indicator_i, interrupt_powerdown_pin_i, mdio_i, mdc}),
    .q       (pin_lvl)
  );

  // management clock is handled as data on clk_sys
  assign mif.mdc_lvl = pin_lvl[0];
  assign mif.mdio_lvl = pin_lvl[1];
  assign pd_lvl = pin_lvl[2];
  assign led_lvl = pin_lvl[3];

  // status word seen by the station
  assign mif.stat = {8'h00, strap_r, led_lvl, powerdown_r, ready_r, link_up};

  prp_mdio #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mdio (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .mif     (mif)
  );

  // config fields
  assign intr_mode = mif.cfg[`PRP_CFG_INTR];
  assign gpio_mode = mif.cfg[`PRP_CFG_LED_GPIO];

  // strap capture on the first enabled edge after release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_r <= 4'h0;
      strap_done_r <= 1'b0;
    end else if (clk_en && !strap_done_r) begin
      strap_r <= strap_i;
      strap_done_r <= 1'b1;
    end
  end

  // reset process: pins stay idle until it ends
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_r <= 5'h00;
      ready_r <= 1'b0;
    end else if (clk_en && !ready_r) begin
      if (init_cnt_r == RST_CYC - 5'h01) begin
        ready_r <= 1'b1;
      end else begin
        init_cnt_r <= init_cnt_r + 5'h01;
      end
    end
  end

  // shared pin: power-down input by default, interrupt when configured
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      powerdown_r <= 1'b0;
      intr_o_r <= 1'b0;
      intr_oe_r <= 1'b0;
    end else if (clk_en) begin
      powerdown_r <= !intr_mode && !pd_lvl;
      intr_o_r <= 1'b0;
      intr_oe_r <= intr_mode && irq_event;
    end
  end

  assign active = ready_r && !powerdown_r;

  // transmit path: the dibit counts only while tx_en is high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_tx_en_r <= 1'b0;
      line_tx_d_r <= 2'h0;
    end else if (clk_en) begin
      if (active && tx_en) begin
        line_tx_en_r <= 1'b1;
        line_tx_d_r <= tx_d;
      end else begin
        // idle line, data bits ignored
        line_tx_en_r <= 1'b0;
        line_tx_d_r <= 2'h0;
      end
    end
  end

  // receive path: data, merged valid, error with self-corruption
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_d_r <= 2'h0;
      crs_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
    end else if (clk_en) begin
      crs_dv_r <= active && (line_crs || line_rx_dv);
      rx_er_r <= active && line_rx_sym_err && (line_crs || line_rx_dv);
      if (!active || !line_rx_dv) begin
        // nothing valid to deliver
        rx_d_r <= 2'h0;
      end else if (line_rx_sym_err) begin
        // inverted dibit breaks the frame check
        rx_d_r <= ~line_rx_d;
      end else begin
        rx_d_r <= line_rx_d;
      end
    end
  end

  assign act_now = active && (tx_en || line_rx_dv);

  // activity hold window, restarted by each active cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_cnt_r <= '0;
    end else if (clk_en) begin
      if (act_now) begin
        act_cnt_r <= BLINK_W'(BLINK_CYC);
      end else if (act_cnt_r != '0) begin
        act_cnt_r <= act_cnt_r - BLINK_W'(1);
      end
    end
  end

  // free-running blink phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_r <= '0;
      blink_ph_r <= 1'b0;
    end else if (clk_en) begin
      if (blink_cnt_r == BLINK_W'(BLINK_CYC - 1)) begin
        blink_cnt_r <= '0;
        blink_ph_r <= ~blink_ph_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + BLINK_W'(1);
      end
    end
  end

  // indicator mode: gpio overrides, then link, then activity
  always_comb begin
    if (gpio_mode) begin
      led_mode = prp_pkg::PRP_LED_GPIO;
    end else if (!link_up || !active) begin
      led_mode = prp_pkg::PRP_LED_OFF;
    end else if (act_now || act_cnt_r != '0) begin
      // the first active cycle already blinks, no steady-on glitch
      led_mode = prp_pkg::PRP_LED_BLINK;
    end else begin
      led_mode = prp_pkg::PRP_LED_ON;
    end
  end

  // indicator pin drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_o_r <= 1'b0;
      led_oe_r <= 1'b1;
    end else if (clk_en) begin
      case (led_mode)
        prp_pkg::PRP_LED_GPIO: begin
          led_o_r <= mif.cfg[`PRP_CFG_LED_VAL];
          led_oe_r <= mif.cfg[`PRP_CFG_LED_DIR];
        end
        prp_pkg::PRP_LED_ON: begin
          led_o_r <= 1'b1;
          led_oe_r <= 1'b1;
        end
        prp_pkg::PRP_LED_BLINK: begin
          led_o_r <= blink_ph_r;
          led_oe_r <= 1'b1;
        end
        default: begin
          led_o_r <= 1'b0;
          led_oe_r <= 1'b1;
        end
      endcase
    end
  end

  // pins
  assign line_tx_en = line_tx_en_r;
  assign line_tx_d = line_tx_d_r;
  assign rx_d = rx_d_r;
  assign crs_dv = crs_dv_r;
  assign rx_er = rx_er_r;
  assign mdio_o = mif.mdio_o;
  assign mdio_oe = mif.mdio_oe;
  assign activity_link_indicator_o = led_o_r;
  assign activity_link_indicator_oe = led_oe_r;
  assign interrupt_powerdown_pin_o = intr_o_r;
  assign interrupt_powerdown_pin_oe = intr_oe_r;
  assign powerdown = powerdown_r;
  assign ready = ready_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_led_steady_on: assert property (
    clk_en && led_mode == prp_pkg::PRP_LED_ON |=> led_o_r && led_oe_r)
    else $error("indicator not on with link up and no activity");
  a_led_blink_phase: assert property (
    clk_en && act_now && link_up && !gpio_mode |=> led_o_r == $past(blink_ph_r))
    else $error("indicator does not follow blink phase on activity");
  a_led_gpio_use: assert property (
    clk_en && gpio_mode |=> led_oe_r == $past(mif.cfg[`PRP_CFG_LED_DIR])
      && led_o_r == $past(mif.cfg[`PRP_CFG_LED_VAL]))
    else $error("indicator pin ignores gpio config");
  a_reset_process: assert property (
    $rose(ready_r) |-> $past(init_cnt_r) == RST_CYC - 5'h01 && strap_done_r)
    else $error("reset process ended at wrong count");
  a_strap_resample: assert property (
    $rose(strap_done_r) |-> strap_r == $past(strap_i) && !ready_r)
    else $error("straps not caught after reset");
  a_rx_data_valid: assert property (
    clk_en && !line_rx_dv |=> rx_d_r == 2'h0)
    else $error("receive bits not idle without valid");
  a_crs_dv_merge: assert property (
    clk_en && active && (line_crs || line_rx_dv) |=> crs_dv_r)
    else $error("crs_dv missed carrier or valid");
  a_rx_err_flag: assert property (
    clk_en && active && line_rx_dv && line_rx_sym_err |=> rx_er_r)
    else $error("rx_er not raised on error symbol");
  a_rx_corrupt: assert property (
    clk_en && active && line_rx_dv && line_rx_sym_err |=> rx_d_r == ~$past(line_rx_d))
    else $error("receive data not corrupted on error");
  a_tx_pass: assert property (
    clk_en && active && tx_en |=> line_tx_en_r && line_tx_d_r == $past(tx_d))
    else $error("transmit dibit not passed while tx_en high");
  a_pd_and_intr: assert property (
    clk_en |=> powerdown_r == $past(!intr_mode && !pd_lvl)
      && intr_oe_r == $past(intr_mode && irq_event) && !interrupt_powerdown_pin_o)
    else $error("shared pin function wrong");
  a_tx_quiet: assert property (
    clk_en && !tx_en |=> !line_tx_en_r && line_tx_d_r == 2'h0)
    else $error("frame data sent while tx_en low");

  c_blink: cover property (led_mode == prp_pkg::PRP_LED_BLINK && clk_en);
  c_rx_error: cover property (rx_er_r && crs_dv_r);
  c_powerdown: cover property ($rose(powerdown_r));
endmodule

// ===== bench/prp_sta_model.sv
/*
  management station model: drives mdc and its own side of mdio.
  assumes the bench resolves the shared data wire with a pull-up.
*/
`timescale 1ns/1ps
`include "prp_params.svh"
module prp_sta_model (
  output logic      mdc,
  output logic      sta_oe,
  output logic      sta_d,
  input  wire logic mdio_w
);
  localparam int HALF = 400;  // slow half period, far below 25 MHz
  // idle: clock low, line released
  initial begin
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_d = 1'b1;
  end
  // one bit: data set while mdc is low, sampled just before the rise
  task automatic bit1(input logic oe, input logic b, output logic s);
    mdc = 1'b0;
    sta_oe = oe;
    sta_d = b;
    #HALF;
    s = mdio_w;
    mdc = 1'b1;
    #HALF;
  endtask
  // whole frame; on reads the line is left to the device after the header
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic        wr;
    logic        s;
    hdr = {32'hFFFF_FFFF, `PRP_MD_ST, op, `PRP_PHY_ADDR, ra};
    wr = (op == `PRP_MD_OP_WR);
    for (int i = 45; i >= 0; i--) bit1(1'b1, hdr[i], s);
    bit1(wr, 1'b1, s);
    bit1(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) bit1(wr, wd[i], rd[i]);
    mdc = 1'b0;
    sta_oe = 1'b0;
  endtask
endmodule

// ===== bench/tb_phy_rmii_pin_behaviour.sv
/*
  self-checking bench of the rmii pin block.
  assumes prp_top and the station model; inputs change 5 ns after each rise.
*/
`timescale 1ns/1ps
`include "prp_params.svh"
module tb_phy_rmii_pin_behaviour;
  logic       clk_sys, rst_n, link_up, irq_event, tx_en, line_rx_dv, line_crs;
  logic       line_rx_sym_err, pd_drv, line_tx_en, crs_dv, rx_er, mdc, mdio_o;
  logic       mdio_oe, sta_oe, sta_d, led_o, led_oe, ipd_o, ipd_oe, powerdown;
  logic       ready, mdio_w, led_w, ipd_w;
  logic [3:0] strap_i;
  logic [1:0] tx_d, line_rx_d, line_tx_d, rx_d;
  logic [15:0] rd;
  int         err_count, check_count;
  // pin resolution: pull-up, pull-down, open drain
  assign mdio_w = mdio_oe ? mdio_o : (sta_oe ? sta_d : 1'b1);
  assign led_w = led_oe ? led_o : 1'b0;
  assign ipd_w = ipd_oe ? 1'b0 : pd_drv;
  prp_top #(.BLINK_CYC(8)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
    .strap_i(strap_i), .link_up(link_up), .irq_event(irq_event), .tx_en(tx_en),
    .tx_d(tx_d), .line_tx_en(line_tx_en), .line_tx_d(line_tx_d),
    .line_rx_dv(line_rx_dv), .line_crs(line_crs), .line_rx_d(line_rx_d),
    .line_rx_sym_err(line_rx_sym_err), .rx_d(rx_d), .crs_dv(crs_dv), .rx_er(rx_er),
    .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .activity_link_indicator_i(led_w), .activity_link_indicator_o(led_o),
    .activity_link_indicator_oe(led_oe), .interrupt_powerdown_pin_i(ipd_w),
    .interrupt_powerdown_pin_o(ipd_o), .interrupt_powerdown_pin_oe(ipd_oe),
    .powerdown(powerdown), .ready(ready));
  prp_sta_model u_sta (.mdc(mdc), .sta_oe(sta_oe), .sta_d(sta_d), .mdio_w(mdio_w));
  // 20 MHz system clock, ideal source with no drift
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset held 6 cycles, then count edges until ready
  task automatic do_rst(input logic [3:0] s);
    int n;
    strap_i = s;
    rst_n = 1'b0;
    step(6);
    chk("ind_oe", 16'h0001, 16'(led_oe));
    chk("ready", 16'h0000, 16'(ready));
    rst_n = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk("ready_edge", 16'h0014, 16'(n));
    if (n == 40) close_out;
    step(6);
  endtask
  task automatic rx1(input logic [4:0] i, input logic [3:0] e);
    {line_rx_dv, line_crs, line_rx_d, line_rx_sym_err} = i;
    step(1);
    chk("rx", 16'(e), {12'h000, crs_dv, rx_er, rx_d});
  endtask
  task automatic mw(input logic [4:0] ra, input logic [15:0] d);
    u_sta.xfer(`PRP_MD_OP_WR, ra, d, rd);
    step(6);
  endtask
  // steady on with link, blinking while transmitting back to back
  task automatic t_led;
    int lo, hi;
    lo = 0;
    hi = 0;
    link_up = 1'b1;
    // let the hold window of the earlier receive activity run out
    step(10);
    chk("led_on", 16'h0001, 16'(led_o));
    tx_en = 1'b1;
    for (int k = 0; k < 24; k++) begin
      tx_d = 2'(k); // mac side changes just after the rise
      step(1);
      chk("tx_d", 16'(4 + k % 4), {13'h0000, line_tx_en, line_tx_d});
      if (led_o === 1'b0) lo++;
      if (led_o === 1'b1) hi++;
    end
    chk("blink", 16'h0001, 16'(lo > 0 && hi > 0));
    tx_en = 1'b0;
    step(1);
    chk("tx_off", 16'h0000, {13'h0000, line_tx_en, line_tx_d});
  endtask
  // power-down pin, then the pin as interrupt output
  task automatic t_pd;
    pd_drv = 1'b0;
    step(6);
    chk("pd", 16'h0001, 16'(powerdown));
    tx_en = 1'b1;
    step(1);
    chk("pd_tx", 16'h0000, 16'(line_tx_en));
    tx_en = 1'b0;
    pd_drv = 1'b1;
    step(6);
    mw(`PRP_REG_CFG, 16'h0008);
    irq_event = 1'b1;
    pd_drv = 1'b0;
    step(6);
    // interrupt mode: pin pulled low, low level no longer powers down
    chk("irq", 16'h0002, {13'h0000, ipd_o, ipd_oe, powerdown});
    irq_event = 1'b0;
    pd_drv = 1'b1;
    step(6);
    chk("irq_off", 16'h0000, 16'(ipd_oe));
  endtask
  initial begin
    {rst_n, link_up, irq_event, tx_en, line_rx_dv, line_crs, line_rx_sym_err} = 7'h00;
    {tx_d, line_rx_d, strap_i, pd_drv, err_count, check_count} = '0;
    pd_drv = 1'b1;
    do_rst(4'hA);
    u_sta.xfer(`PRP_MD_OP_RD, `PRP_REG_STAT, 16'h0000, rd);
    chk("stat", 16'h00A2, rd);
    rx1(5'b11011, 4'hE);
    rx1(5'b11010, 4'h9);
    rx1(5'b01110, 4'h8);
    rx1(5'b00111, 4'h0);
    t_led;
    mw(`PRP_REG_CFG, 16'h0007);
    chk("gpio_hi", 16'h0003, {14'h0000, led_oe, led_o});
    mw(`PRP_REG_CFG, 16'h0003);
    chk("gpio_lo", 16'h0002, {14'h0000, led_oe, led_o});
    // gpio as input: the indicator drive is released
    mw(`PRP_REG_CFG, 16'h0001);
    chk("gpio_in", 16'h0000, {14'h0000, led_oe, led_o});
    t_pd;
    link_up = 1'b0;
    do_rst(4'h5);
    u_sta.xfer(`PRP_MD_OP_RD, `PRP_REG_STAT, 16'h0000, rd);
    chk("stat2", 16'h0052, rd);
    u_sta.xfer(`PRP_MD_OP_RD, `PRP_REG_CFG, 16'h0000, rd);
    chk("cfg2", 16'h0000, rd);
    close_out;
  end
  // cut a hang short
  initial begin
    #2000000;
    err_count++;
    close_out;
  end
endmodule
